// ### verilog/spdsf_top.sv
// Receiver status flags: flags, channel-status block, interrupt, pins.
// Assumes a decoder upstream delivers one sub-frame per strobe, with
// its error bits, on the recovered stream clock.
// Function
// RULE1: Lock flag reads 1 when unlocked or no stream, 0 when locked.
// RULE2: Validity-error flag follows the validity bit: 1 invalid, 0 valid.
// RULE3: Frame-error flag rises on parity, bi-phase or sub-frame order errors.
// RULE4: Channel-status bit 1 is the non-PCM indicator.
// RULE5: Burst-sync flag is 1 while the compressed sync code is seen.
// RULE6: Channel-status bit 2 is an active-low copy flag.
// RULE7: Channel-status bit 3 is the pre-emphasis flag.
// RULE8: Rate code: 00 top class, 01 96k, 10 48k, 11 32k.
// RULE9: Validity bit of current sub-frame is selectable onto a pin.
// RULE10: Channel-status bit of current sub-frame is selectable onto a pin.
// RULE11: Parity bit of current sub-frame is selectable onto a pin.
// RULE12: Block-start is high for exactly frame 0 of each block.
// RULE13: Block-updated rises after a full block whose contents changed.
// RULE14: A pin-selectable bit is high for the top rate class.
// RULE15: Combined non-audio is burst-sync OR the non-PCM bit.
// RULE16: The active-low interrupt can be routed to a pin.
// RULE17: Validity, frame and block-updated interrupt on rising edge only.
// RULE18: Lock, non-audio, copy, pre-emphasis, rate interrupt on any change.
// RULE19: Interrupt holds until status read; stays if edge flags still high.
// RULE20: Masked flags skip interrupt and its status, still update status.
// RULE21: Each pin carries one flag chosen by its own selector; the 8-bit PINSEL write sets pins 0 and 1 only, higher pins stay on SEL_UNLOCK.
// RULE22: Channel-status flags change only from a clean full block.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module spdsf_top #(
    parameter int NUM_PINS = 4
) (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          nrst_in,
    // Recovered stream
    input  wire logic                          locked_in,
    input  wire logic                          sub_stb_in,
    input  wire logic                          sub_a_in,
    input  wire logic                          preamble_z_in,
    input  wire logic                          vbit_in,
    input  wire logic                          ubit_in,
    input  wire logic                          cbit_in,
    input  wire logic                          pbit_in,
    input  wire logic                          parity_err_in,
    input  wire logic                          biphase_err_in,
    input  wire logic                          order_err_in,
    input  wire logic                          sync_code_in,
    input  wire logic [1:0]                    rate_in,
    // Register port
    input  wire logic [spdsf_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [spdsf_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                          wr_in,
    input  wire logic                          rd_in,
    output logic      [spdsf_pkg::DATA_W-1:0]  rdata_out,
    // Flags and pins
    output logic                               irq_n_out,
    output logic                               block_start_out,
    output logic      [NUM_PINS-1:0]           status_out_pin
);
    import spdsf_pkg::*;

    // Flag state.
    logic              unlock_q, unlock_d;
    logic              invalid_q, invalid_d;
    logic              rx_frame_error_q, rx_frame_error_d;
    logic              burst_q, burst_d;
    logic              cs_nonpcm_q, cs_nonpcm_d;
    logic              cs_copy_free_q, cs_copy_free_d;
    logic              cs_preemphasis_q, cs_preemphasis_d;
    logic [1:0]        rx_rate_code_q, rx_rate_code_d;
    logic              cs_block_updated_q, cs_block_updated_d;
    logic              vbit_q, vbit_d, ubit_q, ubit_d;
    logic              cbit_q, cbit_d, pbit_q, pbit_d, suba_q, suba_d;
    // Block state.
    logic [FCNT_W-1:0] frame_q, frame_d;
    logic              block_start_q, block_start_d;
    logic [3:0]        cs_acc_q, cs_acc_d;
    logic              blk_err_q, blk_err_d;
    // Registers and interrupt.
    logic [7:0]        intstat_q, intstat_d;
    logic [7:0]        mask_q, mask_d;
    logic [SEL_W*NUM_PINS-1:0] pinsel_q, pinsel_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              irq_n_q, irq_n_d;
    logic [7:0]        event_w;
    logic              nonaudio_w;
    logic              sub_err_w;
    logic              block_end_w;
    logic [15:0]       flags_w;

    assign nonaudio_w  = burst_q | cs_nonpcm_q; // RULE15
    assign sub_err_w   = parity_err_in | biphase_err_in | order_err_in;
    assign block_end_w = sub_stb_in && !sub_a_in &&
                         (frame_q == FCNT_W'(BLOCK_FRAMES - 1));

    // Flags and channel-status block.
    always_comb begin
        unlock_d           = !locked_in; // RULE1
        invalid_d          = invalid_q;
        rx_frame_error_d   = rx_frame_error_q;
        burst_d            = burst_q;
        cs_nonpcm_d        = cs_nonpcm_q;
        cs_copy_free_d     = cs_copy_free_q;
        cs_preemphasis_d   = cs_preemphasis_q;
        rx_rate_code_d     = locked_in ? rate_in : rx_rate_code_q; // RULE8
        cs_block_updated_d = 1'b0;
        vbit_d             = vbit_q;
        ubit_d             = ubit_q;
        cbit_d             = cbit_q;
        pbit_d             = pbit_q;
        suba_d             = suba_q;
        frame_d            = frame_q;
        block_start_d      = block_start_q;
        cs_acc_d           = cs_acc_q;
        blk_err_d          = blk_err_q;
        if (!locked_in) begin
            blk_err_d = 1'b1; // RULE22
        end else if (sub_stb_in) begin
            invalid_d        = vbit_in; // RULE2
            rx_frame_error_d = sub_err_w; // RULE3
            burst_d          = sync_code_in; // RULE5
            vbit_d = vbit_in; // RULE9
            ubit_d = ubit_in;
            cbit_d = cbit_in; // RULE10
            pbit_d = pbit_in; // RULE11
            suba_d = sub_a_in;
            if (sub_err_w) begin
                blk_err_d = 1'b1;
            end
            if (sub_a_in) begin
                if (preamble_z_in) begin
                    frame_d       = '0;
                    block_start_d = 1'b1; // RULE12
                    cs_acc_d      = '0;
                    blk_err_d     = sub_err_w;
                end else begin
                    frame_d       = frame_q + FCNT_W'(1);
                    block_start_d = 1'b0;
                end
                if (preamble_z_in || frame_q < FCNT_W'(3)) begin
                    if (frame_d < FCNT_W'(4)) begin
                        cs_acc_d[frame_d[1:0]] = cbit_in;
                    end
                end
            end
            if (block_end_w && !blk_err_d) begin
                cs_nonpcm_d      = cs_acc_q[1]; // RULE4 RULE22
                cs_copy_free_d   = cs_acc_q[2]; // RULE6
                cs_preemphasis_d = cs_acc_q[3]; // RULE7
                cs_block_updated_d = (cs_acc_q[3:1] != {cs_preemphasis_q,
                    cs_copy_free_q, cs_nonpcm_q}); // RULE13
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            unlock_q           <= 1'b1;
            invalid_q          <= 1'b0;
            rx_frame_error_q   <= 1'b0;
            burst_q            <= 1'b0;
            cs_nonpcm_q        <= 1'b0;
            cs_copy_free_q     <= 1'b1;
            cs_preemphasis_q   <= 1'b0;
            rx_rate_code_q     <= RATE_RST;
            cs_block_updated_q <= 1'b0;
            vbit_q             <= 1'b0;
            ubit_q             <= 1'b0;
            cbit_q             <= 1'b0;
            pbit_q             <= 1'b0;
            suba_q             <= 1'b0;
            frame_q            <= '0;
            block_start_q      <= 1'b0;
            cs_acc_q           <= '0;
            // A partial block before the first Z preamble after reset is never trusted as complete.
            blk_err_q          <= 1'b1;
        end else begin
            unlock_q           <= unlock_d;
            invalid_q          <= invalid_d;
            rx_frame_error_q   <= rx_frame_error_d;
            burst_q            <= burst_d;
            cs_nonpcm_q        <= cs_nonpcm_d;
            cs_copy_free_q     <= cs_copy_free_d;
            cs_preemphasis_q   <= cs_preemphasis_d;
            rx_rate_code_q     <= rx_rate_code_d;
            cs_block_updated_q <= cs_block_updated_d;
            vbit_q             <= vbit_d;
            ubit_q             <= ubit_d;
            cbit_q             <= cbit_d;
            pbit_q             <= pbit_d;
            suba_q             <= suba_d;
            frame_q            <= frame_d;
            block_start_q      <= block_start_d;
            cs_acc_q           <= cs_acc_d;
            blk_err_q          <= blk_err_d;
        end
    end

    // Events compare next flag values to current ones.
    always_comb begin
        event_w             = '0;
        event_w[IB_LOCK]    = unlock_d != unlock_q; // RULE18
        event_w[IB_INVALID] = invalid_d && !invalid_q; // RULE17
        event_w[IB_CS_BLOCK_UPDATED]    = cs_block_updated_d && !cs_block_updated_q;
        event_w[IB_FRAME]   = rx_frame_error_d && !rx_frame_error_q;
        event_w[IB_NONAUD]  = (burst_d | cs_nonpcm_d) != nonaudio_w;
        event_w[IB_COPY]    = cs_copy_free_d != cs_copy_free_q;
        event_w[IB_PREEMPH] = cs_preemphasis_d != cs_preemphasis_q;
        event_w[IB_RATE]    = rx_rate_code_d != rx_rate_code_q;
    end

    // Register port and interrupt.
    always_comb begin
        intstat_d = intstat_q;
        mask_d    = mask_q;
        pinsel_d  = pinsel_q;
        rdata_d   = '0;
        if (rd_in) begin
            case (addr_in)
                OFS_INTSTAT: begin
                    rdata_d   = intstat_q;
                    intstat_d = '0; // RULE19
                end
                OFS_STATUS:  rdata_d = {1'b0, unlock_q, rx_rate_code_q,
                    cs_preemphasis_q, cs_copy_free_q, burst_q, cs_nonpcm_q};
                OFS_MASK:    rdata_d = mask_q;
                OFS_PINSEL:  rdata_d = DATA_W'(pinsel_q);
                default:     rdata_d = '0;
            endcase
        end
        if (wr_in) begin
            case (addr_in)
                OFS_MASK:   mask_d   = wdata_in;
                OFS_PINSEL: pinsel_d = (SEL_W*NUM_PINS)'(wdata_in);
                default:    ;
            endcase
        end
        // Set wins over the read-clear; edge flags still high re-set.
        intstat_d = intstat_d | (event_w & ~mask_q); // RULE20
        if (rd_in && addr_in == OFS_INTSTAT) begin
            intstat_d[IB_INVALID] = intstat_d[IB_INVALID] |
                (invalid_q & ~mask_q[IB_INVALID]); // RULE19
            intstat_d[IB_FRAME] = intstat_d[IB_FRAME] |
                (rx_frame_error_q & ~mask_q[IB_FRAME]);
            intstat_d[IB_CS_BLOCK_UPDATED] = intstat_d[IB_CS_BLOCK_UPDATED] |
                (cs_block_updated_q & ~mask_q[IB_CS_BLOCK_UPDATED]);
        end
        irq_n_d = ~|intstat_d;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            intstat_q <= '0;
            mask_q    <= MASK_RST;
            pinsel_q  <= (SEL_W*NUM_PINS)'(PINSEL_RST);
            rdata_q   <= '0;
            irq_n_q   <= 1'b1;
        end else begin
            intstat_q <= intstat_d;
            mask_q    <= mask_d;
            pinsel_q  <= pinsel_d;
            rdata_q   <= rdata_d;
            irq_n_q   <= irq_n_d;
        end
    end

    // Flag vector for the pins, indexed by selector code.
    always_comb begin
        flags_w              = '0;
        flags_w[SEL_UNLOCK]  = unlock_q;
        flags_w[SEL_INVALID] = invalid_q;
        flags_w[SEL_FRAME]   = rx_frame_error_q;
        flags_w[SEL_NONAUD]  = nonaudio_w;
        flags_w[SEL_COPY]    = cs_copy_free_q;
        flags_w[SEL_PREEMPH] = cs_preemphasis_q;
        flags_w[SEL_IRQ]     = irq_n_q; // RULE16
        flags_w[SEL_VBIT]    = vbit_q;
        flags_w[SEL_UBIT]    = ubit_q;
        flags_w[SEL_CBIT]    = cbit_q;
        flags_w[SEL_PBIT]    = pbit_q;
        flags_w[SEL_SUBA]    = suba_q;
        flags_w[SEL_BLOCK]   = block_start_q;
        flags_w[SEL_CS_BLOCK_UPDATED]    = cs_block_updated_q;
        flags_w[SEL_TOP]     = rx_rate_code_q == 2'h0; // RULE14
    end

    // One selector per pin; the pin register sits in the mux.
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        spdsf_pin_mux u_mux (
            .clk_in  (clk_in),
            .nrst_in (nrst_in),
            .sel_in  (pinsel_q[i*SEL_W +: SEL_W]),
            .flags_in(flags_w),
            .pin_out (status_out_pin[i])
        );
    end

    assign rdata_out       = rdata_q;
    assign irq_n_out       = irq_n_q;
    assign block_start_out = block_start_q;

    unlock_track_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        1 |=> unlock_q == !$past(locked_in)) else $error("lock flag"); // RULE1
    irq_follow_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (event_w[IB_INVALID] && !mask_q[IB_INVALID]) |=> !irq_n_out)
        else $error("irq missing"); // RULE17
    mask_block_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mask_q == 8'hFF && intstat_q == 8'h00 && !wr_in) |=>
        intstat_q == 8'h00) else $error("masked set"); // RULE20
    rate_change_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!mask_q[IB_RATE] && rx_rate_code_q != $past(rx_rate_code_q)) |->
        intstat_q[IB_RATE]) else $error("rate irq"); // RULE18
    blk_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        block_start_q |-> frame_q == '0) else $error("block start"); // RULE12
    hold_unlock_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !locked_in |=> $stable(cs_copy_free_q))
        else $error("cs changed unlocked"); // RULE22
    upd_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        cs_block_updated_q |-> $past(block_end_w)) else $error("update"); // RULE13
    irq_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!irq_n_q && !rd_in) |=> !irq_n_q) else $error("irq dropped"); // RULE19
endmodule

// ### common/spdsf_pkg.sv
// Package for the receiver status-flag block: register offsets, fields,
// reset values and output-pin selector codes.
// Assumes a byte-free register port with 8-bit data and 8-bit addresses.
package spdsf_pkg;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 8;
    localparam int         BLOCK_FRAMES  = 192;
    localparam int         FCNT_W        = 8;
    localparam int         SEL_W         = 4;
    // Register offsets.
    localparam logic [7:0] OFS_INTSTAT   = 8'h2B;
    localparam logic [7:0] OFS_STATUS    = 8'h31;
    localparam logic [7:0] OFS_MASK      = 8'h2C;
    localparam logic [7:0] OFS_PINSEL    = 8'h2D;
    // Interrupt status and mask bit positions.
    localparam int         IB_LOCK       = 0;
    localparam int         IB_INVALID    = 1;
    localparam int         IB_CS_BLOCK_UPDATED       = 2;
    localparam int         IB_FRAME      = 3;
    localparam int         IB_NONAUD     = 4;
    localparam int         IB_COPY       = 5;
    localparam int         IB_PREEMPH    = 6;
    localparam int         IB_RATE       = 7;
    // Reset values.
    localparam logic [7:0] MASK_RST      = 8'h00;
    localparam logic [7:0] PINSEL_RST    = 8'h10;
    localparam logic [1:0] RATE_RST      = 2'h2;
    // Output-pin selector codes.
    typedef enum logic [3:0] {
        SEL_UNLOCK, SEL_INVALID, SEL_FRAME, SEL_NONAUD, SEL_COPY,
        SEL_PREEMPH, SEL_IRQ, SEL_VBIT, SEL_UBIT, SEL_CBIT, SEL_PBIT,
        SEL_SUBA, SEL_BLOCK, SEL_CS_BLOCK_UPDATED, SEL_TOP
    } spdsf_sel_t;
endpackage

// ### verilog/spdsf_pin_mux.sv
// One general-purpose status pin: registered selection of one flag.
// Assumes the flag vector is indexed by the selector codes of the package.
`timescale 1ns/10ps
module spdsf_pin_mux (
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      nrst_in,
    // Selection
    input  wire logic [spdsf_pkg::SEL_W-1:0] sel_in,
    input  wire logic [15:0]               flags_in,
    // Pin
    output logic                           pin_out
);
    import spdsf_pkg::*;
    logic pin_d;
    logic pin_q;

    always_comb begin
        pin_d = flags_in[sel_in]; // RULE21
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign pin_out = pin_q;
endmodule

// ### bench/spdsf_tx_model.sv
// Stream source model: one sub-frame per strobe, one strobe every GAP
// cycles. Assumes the bench sets lock and rate through set_link.
`timescale 1ns/10ps
module spdsf_tx_model
    import spdsf_pkg::*;
#(
    parameter int GAP = 4
) (
    // Clock
    input  wire logic       clk_in,
    // Link state
    output logic            locked_out,
    output logic [1:0]      rate_out,
    // Sub-frame
    output logic            stb_out,
    output logic            a_out,
    output logic            z_out,
    output logic            v_out,
    output logic            u_out,
    output logic            c_out,
    output logic            p_out,
    output logic            perr_out,
    output logic            berr_out,
    output logic            oerr_out,
    output logic            sync_out
);
    initial begin
        {sync_out, oerr_out, berr_out, perr_out, p_out} = 5'h00;
        {c_out, u_out, v_out, z_out, a_out, stb_out} = 6'h00;
        locked_out = 1'b0;
        rate_out = 2'h2;
    end

    task automatic set_link(input logic lk, input logic [1:0] r);
        @(posedge clk_in);
        locked_out <= lk;
        rate_out <= r;
    endtask

    // Field order: sync, oerr, berr, perr, p, c, u, v, z, a.
    task automatic send_sub(input logic [9:0] f);
        @(posedge clk_in);
        {sync_out, oerr_out, berr_out, perr_out, p_out} <= f[9:5];
        {c_out, u_out, v_out, z_out, a_out} <= f[4:0];
        stb_out <= 1'b1;
        @(posedge clk_in);
        stb_out <= 1'b0;
        // Outside the strobe the lines carry junk, so a design that
        // samples them late sees the inverse rather than a stale value.
        {sync_out, oerr_out, berr_out, perr_out, p_out} <= ~f[9:5];
        {c_out, u_out, v_out, z_out, a_out} <= ~f[4:0];
        repeat (GAP - 2) @(posedge clk_in);
    endtask

    task automatic send_block(input logic [3:1] cs, input logic v,
                              input logic err);
        logic [3:0] csv;
        logic       cb;
        csv = {cs, 1'b0};
        for (int f = 0; f < BLOCK_FRAMES; f++) begin
            for (int s = 0; s < 2; s++) begin
                cb = (s == 0 && f < 4) ? csv[f[1:0]] : 1'b0;
                send_sub({1'b0, err && f == 13 && s == 0,
                          err && f == 9 && s == 0, err && f == 5 && s == 0,
                          cb ^ v, cb, f[0], v, f == 0 && s == 0, s == 0});
            end
        end
    endtask
endmodule

// ### bench/spdif_rx_status_flags_tb.sv
// Bench for the receiver status-flag block: register tests over a
// stream source model. Assumes package and model are compiled first.
`timescale 1ns/10ps
module spdif_rx_status_flags_tb;
    import spdsf_pkg::*;
    localparam int GAP = 4;
    logic       clk_in, nrst_in, wr_in, rd_in, irq_n_out, block_start_out;
    logic       locked, stb, sa, sz, sv, su, sc, sp, pe, be, oe, sy;
    logic [1:0] rate;
    logic [7:0] addr_in, wdata_in, rdata_out, got;
    logic [3:0] status_out_pin;
    int         mismatches, checks_done, bs_len;

    spdsf_tx_model #(.GAP(GAP)) tx (.clk_in(clk_in), .locked_out(locked),
        .rate_out(rate), .stb_out(stb), .a_out(sa), .z_out(sz),
        .v_out(sv), .u_out(su), .c_out(sc), .p_out(sp), .perr_out(pe),
        .berr_out(be), .oerr_out(oe), .sync_out(sy));

    spdsf_top #(.NUM_PINS(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .locked_in(locked), .sub_stb_in(stb), .sub_a_in(sa),
        .preamble_z_in(sz), .vbit_in(sv), .ubit_in(su), .cbit_in(sc),
        .pbit_in(sp), .parity_err_in(pe), .biphase_err_in(be),
        .order_err_in(oe), .sync_code_in(sy), .rate_in(rate),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .irq_n_out(irq_n_out),
        .block_start_out(block_start_out),
        .status_out_pin(status_out_pin));

    task automatic conclude();
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, e, m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            mismatches++;
            $display("BAD %0t reg got %h exp %h mask %h", $time, g, e, m);
        end
    endtask

    task automatic chk_bit(input logic g, e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t bit got %b exp %b", $time, g, e);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, e, m);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, e, m);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // The run needs about 3300 cycles; a hang is cut off well beyond.
    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    always @(negedge clk_in) begin
        if (block_start_out === 1'b1) begin
            bs_len <= bs_len + 1;
        end else if (bs_len != 0) begin
            chk_bit(1'(bs_len == 2 * GAP), 1'b1);
            bs_len <= 0;
        end
    end

    initial begin
        {nrst_in, wr_in, rd_in, addr_in, wdata_in} = 19'h0;
        {mismatches, checks_done, bs_len} = '0;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        chk({irq_n_out, block_start_out, 2'h0, status_out_pin}, 8'h80, 8'hFF);
        rd_chk(OFS_MASK, MASK_RST, 8'hFF);
        rd_chk(OFS_PINSEL, PINSEL_RST, 8'hFF);
        rd_chk(8'h00, 8'h00, 8'hFF);
        rd_chk(OFS_STATUS, {2'h1, RATE_RST, 4'h0}, 8'h70);
        tx.set_link(1'b1, 2'h1);
        settle(3);
        chk_bit(irq_n_out, 1'b0);
        rd_chk(OFS_INTSTAT, 8'h81, 8'h81);
        settle(2);
        chk_bit(irq_n_out, 1'b1);
        rd_chk(OFS_STATUS, 8'h10, 8'h70);
        tx.send_block(3'b101, 1'b0, 1'b0);
        settle(2);
        rd_chk(OFS_STATUS, 8'h19, 8'h7F);
        rd_chk(OFS_INTSTAT, 8'h54, 8'h54);
        reg_wr(OFS_PINSEL, {4'(SEL_COPY), 4'(SEL_NONAUD)});
        settle(2);
        chk_bit(status_out_pin[0], 1'b1);
        chk_bit(status_out_pin[1], 1'b0);
        reg_wr(OFS_PINSEL, {4'(SEL_PREEMPH), 4'(SEL_UNLOCK)});
        settle(2);
        chk_bit(status_out_pin[0], 1'b0);
        chk_bit(status_out_pin[1], 1'b1);
        // Masked frame error must leave the interrupt alone.
        reg_wr(OFS_MASK, 8'hFF);
        tx.send_sub(10'h041);
        tx.send_sub(10'h000);
        chk_bit(irq_n_out, 1'b1);
        rd_chk(OFS_INTSTAT, 8'h00, 8'hFF);
        reg_wr(OFS_MASK, 8'h00);
        for (int k = 6; k < 9; k++) begin
            tx.send_sub(10'h001 | (10'h001 << k));
            chk_bit(irq_n_out, 1'b0);
            tx.send_sub(10'h000);
            rd_chk(OFS_INTSTAT, 8'h08, 8'h08);
            settle(2);
            chk_bit(irq_n_out, 1'b1);
        end
        tx.send_block(3'b010, 1'b0, 1'b1);
        settle(2);
        rd_chk(OFS_STATUS, 8'h19, 8'h0D);
        rd_chk(OFS_INTSTAT, 8'h08, 8'h0C);
        for (int k = 2; k < 6; k++) begin
            reg_wr(OFS_PINSEL, {4'(SEL_BLOCK), 4'(5 + k)});
            tx.send_sub(10'h001 | (10'h001 << k));
            settle(1);
            chk_bit(status_out_pin[0], 1'b1);
            tx.send_sub(10'h000);
            settle(1);
            chk_bit(status_out_pin[0], 1'b0);
        end
        rd_chk(OFS_INTSTAT, 8'h02, 8'h02);
        tx.send_sub(10'h201);
        rd_chk(OFS_STATUS, 8'h02, 8'h02);
        tx.send_sub(10'h000);
        rd_chk(OFS_STATUS, 8'h00, 8'h02);
        reg_wr(OFS_PINSEL, {4'(SEL_TOP), 4'(SEL_IRQ)});
        for (int r = 3; r >= 0; r--) begin
            tx.set_link(1'b1, 2'(r));
            settle(3);
            chk_bit(status_out_pin[1], 1'(r == 0));
            rd_chk(OFS_STATUS, 8'(r << 4), 8'h30);
        end
        chk_bit(irq_n_out, 1'b0);
        chk_bit(status_out_pin[0], 1'b0);
        rd_chk(OFS_INTSTAT, 8'h80, 8'h80);
        settle(2);
        chk_bit(status_out_pin[0], 1'b1);
        tx.set_link(1'b0, 2'h0);
        settle(3);
        rd_chk(OFS_STATUS, 8'h40, 8'h70);
        rd_chk(OFS_INTSTAT, 8'h01, 8'h01);
        conclude();
    end
endmodule
